// *** shared/cls_key_aux_regs.svh ***
// Function
// - Strip flag tells rewriter bytes before pointer
// - Last stripping action sets the byte count
// - Rewriter strips at most 42 bytes
// - Key DSCP from frame or classified value
// - Key outer tag from frame, port VLAN if untagged, or classified
// - Source options touch only keys with fields
// - Front port: kind 0, own port bit
// - Looped: kind 1 or 3, loop port
// - Masqueraded: kind 0 or 2, masquerade port
// - Virtual device: kind 0 or 3, original port
// - Processor injected: kind 0 or 3, empty
// - Eight range checkers form match vector
// - Port ranges: destination, source, either, TCP/UDP
// - Also VID, DSCP for IP, or EtherType
// - Range inclusive of both end points
// - Generic index of next lookup from action
// - Index derived from chain control and value
// - Advance above 66 bytes cancelled, sticky flagged
`ifndef CLS_KEY_AUX_REGS_SVH
`define CLS_KEY_AUX_REGS_SVH
`define NUM_PORTS 8
`define NUM_LOOKUPS 6
`define NUM_RANGES 8
`define REG_PORT_CFG_BASE 6'h00
`define REG_MISC 6'h08
`define REG_RNG_TYPE_BASE 6'h10
`define REG_RNG_BND_BASE 6'h18
`define REG_STATUS 6'h20
`define CFG_TAG_LSB 8
`define MISC_LOOP_KIND3 0
`define MISC_MASQ_KIND2 1
`define MISC_VDEV_KIND3 2
`define MISC_CPU_KIND3 3
`define ST_ADV_FAIL 0
`define ST_STRIP_CLAMP 1
`define ST_PTR_LSB 8
`define ST_STRIP_LSB 16
`define BND_HI_LSB 16
`define RST_REG 32'h0000_0000
`define MAX_STRIP_BYTES 8'h2A
`define MAX_ADVANCE_BYTES 8'h42
`define KIND_0 2'h0
`define KIND_1 2'h1
`define KIND_2 2'h2
`define KIND_3 2'h3
`endif

// *** shared/cls_key_aux_pkg.sv ***
`default_nettype none
package cls_key_aux_pkg;
    typedef enum logic [2:0] {
        ORG_FRONT = 3'h0,
        ORG_LOOP = 3'h1,
        ORG_MASQ = 3'h2,
        ORG_VDEV = 3'h3,
        ORG_CPU = 3'h4
    } origin_e;
    typedef enum logic [2:0] {
        RNG_DPORT = 3'h0,
        RNG_SPORT = 3'h1,
        RNG_EITHER = 3'h2,
        RNG_VID = 3'h3,
        RNG_DSCP = 3'h4,
        RNG_ETYPE = 3'h5
    } range_type_e;
    typedef enum logic [1:0] {
        CHAIN_NONE = 2'h0,
        CHAIN_SET = 2'h1,
        CHAIN_ADD = 2'h2,
        CHAIN_KEEP = 2'h3
    } chain_ctrl_e;
    typedef enum logic {
        FR_IDLE = 1'b0,
        FR_ACTIVE = 1'b1
    } frame_state_e;
endpackage
`default_nettype wire

// *** logic/range_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module range_checker (
    input wire logic [2:0] rng_type,
    input wire logic [15:0] lo,
    input wire logic [15:0] hi,
    input wire logic is_l4,
    input wire logic is_ip,
    input wire logic [15:0] sport,
    input wire logic [15:0] dport,
    input wire logic [11:0] cl_vid,
    input wire logic [5:0] cl_dscp,
    input wire logic [15:0] etype,
    output logic match
);
    import cls_key_aux_pkg::*;

    function automatic logic in_range(input logic [15:0] v,
                                      input logic [15:0] l,
                                      input logic [15:0] h);
        in_range = (v >= l) && (v <= h);
    endfunction

    always_comb begin
        unique case (rng_type)
            RNG_DPORT: match = is_l4 && in_range(dport, lo, hi);
            RNG_SPORT: match = is_l4 && in_range(sport, lo, hi);
            RNG_EITHER: match = is_l4 && (in_range(sport, lo, hi) ||
                                in_range(dport, lo, hi));
            RNG_VID: match = in_range({4'h0, cl_vid}, lo, hi);
            RNG_DSCP: match = is_ip &&
                              in_range({10'h000, cl_dscp}, lo, hi);
            RNG_ETYPE: match = in_range(etype, lo, hi);
            default: match = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// *** logic/src_mask_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cls_key_aux_regs.svh"
module src_mask_gen (
    input wire cls_key_aux_pkg::origin_e origin,
    input wire logic [2:0] phys_port,
    input wire logic [2:0] loop_port,
    input wire logic [2:0] masq_port,
    input wire logic [2:0] orig_port,
    input wire logic [3:0] misc,
    output logic [1:0] kind,
    output logic [`NUM_PORTS-1:0] bitmap
);
    import cls_key_aux_pkg::*;

    function automatic logic [`NUM_PORTS-1:0] one_bit(input logic [2:0] p);
        one_bit = {{(`NUM_PORTS-1){1'b0}}, 1'b1} << p;
    endfunction

    always_comb begin
        kind = `KIND_0;
        bitmap = '0;
        unique case (origin)
            ORG_FRONT: begin
                kind = `KIND_0;
                bitmap = one_bit(phys_port);
            end
            ORG_LOOP: begin
                kind = misc[`MISC_LOOP_KIND3] ? `KIND_3 : `KIND_1;
                bitmap = one_bit(loop_port);
            end
            ORG_MASQ: begin
                kind = misc[`MISC_MASQ_KIND2] ? `KIND_2 : `KIND_0;
                bitmap = one_bit(masq_port);
            end
            ORG_VDEV: begin
                kind = misc[`MISC_VDEV_KIND3] ? `KIND_3 : `KIND_0;
                bitmap = one_bit(orig_port);
            end
            ORG_CPU: begin
                kind = misc[`MISC_CPU_KIND3] ? `KIND_3 : `KIND_0;
                bitmap = '0;
            end
            default: begin
                kind = `KIND_0;
                bitmap = '0;
            end
        endcase
    end
endmodule
`default_nettype wire

// *** logic/classifier_key_aux_logic.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cls_key_aux_regs.svh"
module classifier_key_aux_logic (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic frame_start,
    input wire logic frame_end,
    input wire logic act_valid,
    input wire logic act_strip,
    input wire logic [7:0] act_advance,
    input wire cls_key_aux_pkg::chain_ctrl_e act_chain_ctrl,
    input wire logic [11:0] act_chain_value,
    input wire logic key_req,
    input wire logic [2:0] key_port,
    input wire logic [2:0] key_lkp,
    input wire logic key_has_dscp,
    input wire logic key_has_tag,
    input wire logic key_has_mask,
    input wire logic key_has_range,
    input wire cls_key_aux_pkg::origin_e origin,
    input wire logic [2:0] loop_port,
    input wire logic [2:0] masq_port,
    input wire logic [2:0] orig_port,
    input wire logic [5:0] frame_dscp,
    input wire logic [5:0] cl_dscp,
    input wire logic frame_tagged,
    input wire logic [11:0] frame_vid,
    input wire logic [2:0] frame_pcp,
    input wire logic frame_dei,
    input wire logic [11:0] pvid_vid,
    input wire logic [2:0] pvid_pcp,
    input wire logic pvid_dei,
    input wire logic [11:0] cl_vid,
    input wire logic [2:0] cl_pcp,
    input wire logic cl_dei,
    input wire logic is_l4,
    input wire logic is_ip,
    input wire logic [15:0] l4_sport,
    input wire logic [15:0] l4_dport,
    input wire logic [15:0] etype,
    output logic key_valid,
    output logic [5:0] key_dscp_field,
    output logic [11:0] outer_vid_field,
    output logic [2:0] outer_pcp_field,
    output logic outer_dei_field,
    output logic [1:0] src_mask_kind,
    output logic [`NUM_PORTS-1:0] src_port_bitmap,
    output logic [`NUM_RANGES-1:0] range_match_vector,
    output logic [11:0] g_idx,
    output logic [7:0] frame_ptr,
    output logic strip_valid,
    output logic [7:0] strip_len
);
    import cls_key_aux_pkg::*;

    function automatic logic sel(input logic [5:0] idx,
                                 input logic [5:0] base,
                                 input int n);
        sel = (idx >= base) && (idx < base + 6'(n));
    endfunction

    // Register file
    logic [31:0] port_cfg [`NUM_PORTS];
    logic [31:0] misc_cfg;
    logic [2:0] rng_type [`NUM_RANGES];
    logic [31:0] rng_bnd [`NUM_RANGES];
    logic [31:0] next_port_cfg [`NUM_PORTS];
    logic [31:0] next_misc_cfg;
    logic [2:0] next_rng_type [`NUM_RANGES];
    logic [31:0] next_rng_bnd [`NUM_RANGES];
    logic [31:0] next_reg_rdata;
    logic adv_fail;
    logic strip_clamp;
    logic [5:0] widx;
    logic [2:0] wsub;

    assign widx = reg_addr[7:2];
    assign wsub = widx[2:0];

    always_comb begin
        next_port_cfg = port_cfg;
        next_misc_cfg = misc_cfg;
        next_rng_type = rng_type;
        next_rng_bnd = rng_bnd;
        next_reg_rdata = '0;
        if (reg_wr) begin
            if (sel(widx, `REG_PORT_CFG_BASE, `NUM_PORTS))
                next_port_cfg[wsub] = reg_wdata;
            if (widx == `REG_MISC)
                next_misc_cfg = {28'h0000000, reg_wdata[3:0]};
            if (sel(widx, `REG_RNG_TYPE_BASE, `NUM_RANGES))
                next_rng_type[wsub] = reg_wdata[2:0];
            if (sel(widx, `REG_RNG_BND_BASE, `NUM_RANGES))
                next_rng_bnd[wsub] = reg_wdata;
        end
        if (reg_rd) begin
            if (sel(widx, `REG_PORT_CFG_BASE, `NUM_PORTS))
                next_reg_rdata = port_cfg[wsub] & 32'h0000_3F3F;
            else if (widx == `REG_MISC)
                next_reg_rdata = misc_cfg;
            else if (sel(widx, `REG_RNG_TYPE_BASE, `NUM_RANGES))
                next_reg_rdata = {29'h00000000, rng_type[wsub]};
            else if (sel(widx, `REG_RNG_BND_BASE, `NUM_RANGES))
                next_reg_rdata = rng_bnd[wsub];
            else if (widx == `REG_STATUS)
                next_reg_rdata = {8'h00, strip_len, frame_ptr, 6'h00,
                                  strip_clamp, adv_fail};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `NUM_PORTS; i++)
                port_cfg[i] <= `RST_REG;
            for (int i = 0; i < `NUM_RANGES; i++) begin
                rng_type[i] <= 3'h0;
                rng_bnd[i] <= `RST_REG;
            end
            misc_cfg <= `RST_REG;
            reg_rdata <= `RST_REG;
        end else begin
            port_cfg <= next_port_cfg;
            rng_type <= next_rng_type;
            rng_bnd <= next_rng_bnd;
            misc_cfg <= next_misc_cfg;
            reg_rdata <= next_reg_rdata;
        end
    end

    // Per-frame lookup chain
    frame_state_e state;
    frame_state_e next_state;
    logic [7:0] next_frame_ptr;
    logic [11:0] next_g_idx;
    logic [7:0] next_strip_len;
    logic next_strip_valid;
    logic next_adv_fail;
    logic next_strip_clamp;
    logic [7:0] moved_ptr;
    logic act_take;
    logic st_clear;

    assign act_take = act_valid && (state == FR_ACTIVE) && !frame_start;
    assign st_clear = reg_wr && (widx == `REG_STATUS);

    always_comb begin
        next_state = state;
        next_frame_ptr = frame_ptr;
        next_g_idx = g_idx;
        next_strip_len = strip_len;
        next_strip_valid = 1'b0;
        next_adv_fail = adv_fail && !(st_clear && reg_wdata[`ST_ADV_FAIL]);
        next_strip_clamp = strip_clamp &&
                           !(st_clear && reg_wdata[`ST_STRIP_CLAMP]);
        moved_ptr = frame_ptr + act_advance;
        unique case (state)
            FR_IDLE: begin
                if (frame_start)
                    next_state = FR_ACTIVE;
            end
            FR_ACTIVE: begin
                if (frame_end) begin
                    next_state = FR_IDLE;
                    next_strip_valid = 1'b1;
                end
            end
        endcase
        if (frame_start) begin
            next_frame_ptr = '0;
            next_g_idx = '0;
            next_strip_len = '0;
        end else if (act_take) begin
            if (act_advance > `MAX_ADVANCE_BYTES) begin
                moved_ptr = frame_ptr;
                next_adv_fail = 1'b1;
            end
            next_frame_ptr = moved_ptr;
            if (act_strip) begin
                // A later stripping action overwrites the count
                if (moved_ptr > `MAX_STRIP_BYTES) begin
                    next_strip_len = `MAX_STRIP_BYTES;
                    next_strip_clamp = 1'b1;
                end else begin
                    next_strip_len = moved_ptr;
                end
            end
            unique case (act_chain_ctrl)
                CHAIN_NONE: next_g_idx = '0;
                CHAIN_SET: next_g_idx = act_chain_value;
                CHAIN_ADD: next_g_idx = g_idx + act_chain_value;
                CHAIN_KEEP: next_g_idx = g_idx;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FR_IDLE;
            frame_ptr <= 8'h00;
            g_idx <= 12'h000;
            strip_len <= 8'h00;
            strip_valid <= 1'b0;
            adv_fail <= 1'b0;
            strip_clamp <= 1'b0;
        end else begin
            state <= next_state;
            frame_ptr <= next_frame_ptr;
            g_idx <= next_g_idx;
            strip_len <= next_strip_len;
            strip_valid <= next_strip_valid;
            adv_fail <= next_adv_fail;
            strip_clamp <= next_strip_clamp;
        end
    end

    // Key field generation
    logic dscp_cl_sel;
    logic tag_cl_sel;
    logic [1:0] mask_kind;
    logic [`NUM_PORTS-1:0] mask_bits;
    logic [`NUM_RANGES-1:0] rng_hits;
    logic [5:0] next_key_dscp;
    logic [11:0] next_vid;
    logic [2:0] next_pcp;
    logic next_dei;
    logic [1:0] next_kind;
    logic [`NUM_PORTS-1:0] next_bitmap;
    logic [`NUM_RANGES-1:0] next_rng_vec;
    logic [31:0] cfg_now;

    src_mask_gen u_mask (
        .origin(origin),
        .phys_port(key_port),
        .loop_port(loop_port),
        .masq_port(masq_port),
        .orig_port(orig_port),
        .misc(misc_cfg[3:0]),
        .kind(mask_kind),
        .bitmap(mask_bits)
    );

    generate
        for (genvar r = 0; r < `NUM_RANGES; r++) begin : g_rng
            range_checker u_rng (
                .rng_type(rng_type[r]),
                .lo(rng_bnd[r][15:0]),
                .hi(rng_bnd[r][31:`BND_HI_LSB]),
                .is_l4(is_l4),
                .is_ip(is_ip),
                .sport(l4_sport),
                .dport(l4_dport),
                .cl_vid(cl_vid),
                .cl_dscp(cl_dscp),
                .etype(etype),
                .match(rng_hits[r])
            );
        end
    endgenerate

    always_comb begin
        cfg_now = port_cfg[key_port];
        dscp_cl_sel = (key_lkp < 3'(`NUM_LOOKUPS)) && cfg_now[key_lkp];
        tag_cl_sel = (key_lkp < 3'(`NUM_LOOKUPS)) &&
                     cfg_now[`CFG_TAG_LSB + 32'(key_lkp)];
        next_key_dscp = '0;
        next_vid = '0;
        next_pcp = '0;
        next_dei = 1'b0;
        if (key_has_dscp)
            next_key_dscp = dscp_cl_sel ? cl_dscp : frame_dscp;
        if (key_has_tag) begin
            if (tag_cl_sel) begin
                next_vid = cl_vid;
                next_pcp = cl_pcp;
                next_dei = cl_dei;
            end else if (frame_tagged) begin
                next_vid = frame_vid;
                next_pcp = frame_pcp;
                next_dei = frame_dei;
            end else begin
                next_vid = pvid_vid;
                next_pcp = pvid_pcp;
                next_dei = pvid_dei;
            end
        end
        next_kind = key_has_mask ? mask_kind : `KIND_0;
        next_bitmap = key_has_mask ? mask_bits : '0;
        next_rng_vec = key_has_range ? rng_hits : '0;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            key_valid <= 1'b0;
            key_dscp_field <= 6'h00;
            outer_vid_field <= 12'h000;
            outer_pcp_field <= 3'h0;
            outer_dei_field <= 1'b0;
            src_mask_kind <= 2'h0;
            src_port_bitmap <= '0;
            range_match_vector <= '0;
        end else begin
            key_valid <= key_req;
            if (key_req) begin
                key_dscp_field <= next_key_dscp;
                outer_vid_field <= next_vid;
                outer_pcp_field <= next_pcp;
                outer_dei_field <= next_dei;
                src_mask_kind <= next_kind;
                src_port_bitmap <= next_bitmap;
                range_match_vector <= next_rng_vec;
            end
        end
    end

    adv_cancel_a: assert property (@(posedge mclk) disable iff (!rst_n)
        act_take && act_advance > `MAX_ADVANCE_BYTES
        |=> frame_ptr == $past(frame_ptr) && adv_fail)
        else $error("oversized advance not cancelled");
    ptr_move_a: assert property (@(posedge mclk) disable iff (!rst_n)
        act_take && act_advance <= `MAX_ADVANCE_BYTES
        |=> frame_ptr == 8'($past(frame_ptr) + $past(act_advance)))
        else $error("frame pointer advance wrong");
    strip_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
        strip_valid |-> strip_len <= `MAX_STRIP_BYTES)
        else $error("strip count above limit");
    strip_last_a: assert property (@(posedge mclk) disable iff (!rst_n)
        act_take && act_strip && moved_ptr <= `MAX_STRIP_BYTES
        ##1 (!act_take && !frame_start)[*2] |-> strip_len == $past(moved_ptr, 2))
        else $error("strip count not from last action");
    dscp_src_a: assert property (@(posedge mclk) disable iff (!rst_n)
        key_req && key_has_dscp
        |=> key_valid && key_dscp_field ==
            ($past(dscp_cl_sel) ? $past(cl_dscp) : $past(frame_dscp)))
        else $error("key DSCP source wrong");
    field_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        key_req && !key_has_dscp && !key_has_tag
        |=> key_dscp_field == 6'h00 && outer_vid_field == 12'h000)
        else $error("absent field not zero");
    front_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
        key_req && key_has_mask && origin == ORG_FRONT
        |=> src_mask_kind == `KIND_0 &&
            src_port_bitmap == (8'h01 << $past(key_port)))
        else $error("front port mask wrong");
    gidx_chain_a: assert property (@(posedge mclk) disable iff (!rst_n)
        act_take && act_chain_ctrl == CHAIN_SET
        |=> g_idx == $past(act_chain_value))
        else $error("generic index not chained");
    gidx_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        frame_start |=> g_idx == 12'h000)
        else $error("generic index not cleared");
endmodule
`default_nettype wire

// *** sim/lookup_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module lookup_model (
    input wire logic mclk,
    input wire logic strip_valid,
    input wire logic [7:0] strip_len,
    output logic act_valid,
    output logic act_strip,
    output logic [7:0] act_advance,
    output cls_key_aux_pkg::chain_ctrl_e act_chain_ctrl,
    output logic [11:0] act_chain_value,
    output logic [7:0] rw_len
);
    import cls_key_aux_pkg::*;
    initial begin
        act_valid = 1'b0;
        act_strip = 1'b0;
        act_advance = 8'h00;
        act_chain_ctrl = CHAIN_NONE;
        act_chain_value = 12'h000;
        rw_len = 8'h00;
    end
    // One action; fields turn to their inverse once released
    task automatic send(input logic [7:0] a, input logic s,
                        input chain_ctrl_e c, input logic [11:0] v);
        @(posedge mclk);
        act_valid <= 1'b1;
        act_strip <= s;
        act_advance <= a;
        act_chain_ctrl <= c;
        act_chain_value <= v;
        @(posedge mclk);
        act_valid <= 1'b0;
        act_strip <= ~s;
        act_advance <= ~a;
        act_chain_ctrl <= chain_ctrl_e'(~c);
        act_chain_value <= ~v;
    endtask
    // Rewriter keeps the last announced strip count
    always @(posedge mclk) begin
        if (strip_valid) begin
            rw_len <= strip_len;
        end
    end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cls_key_aux_pkg::*;
    logic mclk, rst_n, reg_wr, reg_rd, frame_start, frame_end, key_req;
    logic act_valid, act_strip, key_valid, strip_valid, outer_dei_field;
    logic key_has_dscp, key_has_tag, key_has_mask, key_has_range;
    logic frame_tagged, frame_dei, pvid_dei, cl_dei, is_l4, is_ip;
    logic [7:0] reg_addr, act_advance, frame_ptr, strip_len, rw_len;
    logic [7:0] src_port_bitmap, range_match_vector, eptr, elen;
    logic [31:0] reg_wdata, reg_rdata, seed, rv, rw, rd_val;
    logic [11:0] act_chain_value, frame_vid, pvid_vid, cl_vid, g_idx, eg;
    logic [11:0] outer_vid_field;
    logic [2:0] key_port, key_lkp, loop_port, masq_port, orig_port;
    logic [2:0] frame_pcp, pvid_pcp, cl_pcp, outer_pcp_field, rtyp [8];
    logic [5:0] frame_dscp, cl_dscp, key_dscp_field;
    logic [15:0] l4_sport, l4_dport, etype;
    logic [1:0] src_mask_kind, est;
    logic [15:0] pcfg [8];
    logic [3:0] misc;
    logic [31:0] rbnd [8];
    logic [9:0] mk;
    logic [15:0] tg;
    chain_ctrl_e act_chain_ctrl;
    origin_e origin;
    int failures, samples_checked;

    assign mk = {src_mask_kind, src_port_bitmap};
    assign tg = {outer_vid_field, outer_pcp_field, outer_dei_field};
    classifier_key_aux_logic dut (.*);
    lookup_model eng (.*);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #600000;
        failures++;
        final_report();
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic inr(input logic [15:0] x, l, h);
        return x >= l && x <= h;
    endfunction
    function automatic logic [7:0] exp_rng();
        logic [7:0] v;
        logic [15:0] l, h;
        v = 8'h00;
        for (int r = 0; r < 8; r++) begin
            l = rbnd[r][15:0];
            h = rbnd[r][31:16];
            case (rtyp[r])
                3'h0: v[r] = is_l4 && inr(l4_dport, l, h);
                3'h1: v[r] = is_l4 && inr(l4_sport, l, h);
                3'h2: v[r] = is_l4 && (inr(l4_sport, l, h) ||
                                       inr(l4_dport, l, h));
                3'h3: v[r] = inr({4'h0, cl_vid}, l, h);
                3'h4: v[r] = is_ip && inr({10'h000, cl_dscp}, l, h);
                3'h5: v[r] = inr(etype, l, h);
                default: v[r] = 1'b0;
            endcase
        end
        return v;
    endfunction
    function automatic logic [9:0] exp_mask();
        case (origin)
            ORG_FRONT: return {2'h0, 8'h01 << key_port};
            ORG_LOOP: return {misc[0] ? 2'h3 : 2'h1, 8'h01 << loop_port};
            ORG_MASQ: return {misc[1] ? 2'h2 : 2'h0, 8'h01 << masq_port};
            ORG_VDEV: return {misc[2] ? 2'h3 : 2'h0, 8'h01 << orig_port};
            default: return {misc[3] ? 2'h3 : 2'h0, 8'h00};
        endcase
    endfunction

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        samples_checked++;
        if (e !== s) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic cfg_all(input int b);
        for (int i = 0; i < 8; i++) begin
            rv = rnd();
            pcfg[i] = rv[15:0] & 16'h3F3F;
            rtyp[i] = rv[18:16];
            rbnd[i] = {12'h000, rv[23:20], 12'h000, rv[27:24]};
            wr(8'(4 * i), rv);
            wr(8'(8'h40 + 4 * i), {29'h0, rtyp[i]});
            wr(8'(8'h60 + 4 * i), rbnd[i]);
            rd(8'(4 * i));
            chk("port_cfg", {16'h0, pcfg[i]}, rd_val);
        end
        misc = b[0] ? 4'hF : 4'h0;
        wr(8'h20, {28'h0, misc});
        rd(8'hFC);
        chk("unmapped", 32'h0, rd_val);
    endtask
    task automatic key_one();
        logic [5:0] ed;
        logic [15:0] et;
        rv = rnd();
        rw = rnd();
        @(posedge mclk);
        key_req <= 1'b1;
        key_port <= rv[2:0];
        key_lkp <= rv[5:3];
        {key_has_dscp, key_has_tag, key_has_mask, key_has_range} <= rv[9:6];
        origin <= origin_e'(3'(rv[12:10] % 5));
        {loop_port, masq_port, orig_port} <= rv[21:13];
        {frame_tagged, frame_dei, pvid_dei, cl_dei, is_l4, is_ip}
            <= rv[27:22];
        {frame_pcp, pvid_pcp, cl_pcp} <= rw[8:0];
        {frame_vid, pvid_vid} <= {rw[31:9], rv[28]};
        frame_dscp <= rw[14:9];
        cl_dscp <= {2'h0, rw[18:15]};
        cl_vid <= {8'h00, rw[22:19]};
        {l4_sport, l4_dport, etype} <= {12'h000, rw[26:23], 12'h000,
                                        rw[30:27], 12'h000, rv[31:28]};
        @(posedge mclk);
        key_req <= 1'b0;
        #1;
        ed = !key_has_dscp ? 6'h00 :
             pcfg[key_port][key_lkp] ? cl_dscp : frame_dscp;
        et = !key_has_tag ? 16'h0000 :
             pcfg[key_port][8 + key_lkp] ? {cl_vid, cl_pcp, cl_dei} :
             frame_tagged ? {frame_vid, frame_pcp, frame_dei} :
             {pvid_vid, pvid_pcp, pvid_dei};
        chk("key_valid", 32'h1, {31'h0, key_valid});
        chk("dscp", ed, key_dscp_field);
        chk("tag", et, tg);
        chk("mask", key_has_mask ? exp_mask() : 10'h0, mk);
        chk("range", key_has_range ? exp_rng() : 8'h00,
            range_match_vector);
    endtask
    task automatic fs();
        @(posedge mclk);
        frame_start <= 1'b1;
        @(posedge mclk);
        frame_start <= 1'b0;
        eptr = 8'h00;
        elen = 8'h00;
        eg = 12'h000;
        #1;
        chk("frame_clr", 32'h0, {frame_ptr, strip_len, g_idx});
    endtask
    task automatic act(input logic [7:0] a, input logic s,
                       input chain_ctrl_e c, input logic [11:0] v);
        eng.send(a, s, c, v);
        if (a <= 8'h42) eptr = eptr + a;
        else est[0] = 1'b1;
        if (s) elen = eptr > 8'h2A ? 8'h2A : eptr;
        if (s && eptr > 8'h2A) est[1] = 1'b1;
        case (c)
            CHAIN_NONE: eg = 12'h000;
            CHAIN_SET: eg = v;
            CHAIN_ADD: eg = eg + v;
            default: ;
        endcase
        #1;
        chk("frame_ptr", eptr, frame_ptr);
        chk("strip_len", elen, strip_len);
        chk("g_idx", eg, g_idx);
    endtask
    task automatic fe();
        @(posedge mclk);
        frame_end <= 1'b1;
        @(posedge mclk);
        frame_end <= 1'b0;
        #1;
        chk("strip_out", {1'b1, elen}, {strip_valid, strip_len});
        @(posedge mclk);
        #1;
        chk("rewriter", elen, rw_len);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        seed = 32'h0000878B;
        {rst_n, reg_wr, reg_rd, frame_start, frame_end, key_req} = 6'h00;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        {key_port, key_lkp, loop_port, masq_port, orig_port} = 15'h0;
        {frame_pcp, pvid_pcp, cl_pcp} = 9'h000;
        {key_has_dscp, key_has_tag, key_has_mask, key_has_range} = 4'h0;
        {frame_tagged, frame_dei, pvid_dei, cl_dei, is_l4, is_ip} = 6'h00;
        {frame_vid, pvid_vid, cl_vid, frame_dscp, cl_dscp} = 48'h0;
        {l4_sport, l4_dport, etype} = 48'h0;
        origin = ORG_FRONT;
        est = 2'h0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk("reset", 32'h0, {key_valid, strip_valid, frame_ptr, g_idx});
        fs();
        act(8'h0E, 1'b1, CHAIN_SET, 12'h005);
        act(8'h0A, 1'b0, CHAIN_ADD, 12'h003);
        act(8'h43, 1'b0, CHAIN_KEEP, 12'h7FF);
        act(8'h42, 1'b1, CHAIN_NONE, 12'h123);
        fe();
        eng.send(8'h05, 1'b1, CHAIN_SET, 12'h009);
        #1;
        chk("idle_act", {eptr, elen, eg}, {frame_ptr, strip_len, g_idx});
        rd(8'h80);
        chk("status", {8'h00, elen, eptr, 6'h00, est}, rd_val);
        wr(8'h80, 32'h3);
        est = 2'h0;
        rd(8'h80);
        chk("status_clr", {8'h00, elen, eptr, 8'h00}, rd_val);
        for (int f = 0; f < 12; f++) begin
            fs();
            for (int k = 0; k <= f % 6; k++) begin
                rv = rnd();
                act(rv[7] ? 8'h43 + rv[2:0] : 8'(rv[5:0] % 40), rv[22],
                    chain_ctrl_e'(rv[9:8]), rv[21:10]);
            end
            fe();
        end
        for (int b = 0; b < 4; b++) begin
            cfg_all(b);
            repeat (25) key_one();
        end
        final_report();
    end
endmodule
`default_nettype wire
